// ---- shared/lsq_params.svh ----
// constants for the led string start-up and fault sequencer
`ifndef LSQ_PARAMS_SVH
`define LSQ_PARAMS_SVH
`define LSQ_CLK_MHZ 125
`define LSQ_NCH 8
`define LSQ_SELW 3
`define LSQ_CNTW 26
`define LSQ_DETECT_US 256
`define LSQ_SOFT_MS 128
`define LSQ_BLANK_MS 256
`define LSQ_SHDN_MS 32
`define LSQ_US_CYC(us) ((us) * `LSQ_CLK_MHZ)
`define LSQ_MS_CYC(ms) ((ms) * 1000 * `LSQ_CLK_MHZ)
`endif

// ---- shared/lsq_pkg.sv ----
// types for the led string start-up and fault sequencer
`include "lsq_params.svh"
package lsq_pkg;
   typedef enum logic [2:0] {
      ST_OFF,
      ST_DETECT,
      ST_SOFT,
      ST_BLANK,
      ST_RUN,
      ST_FAULT
   } lsq_state_t;

   typedef struct packed {
      lsq_state_t st;
      logic [`LSQ_CNTW-1:0] cnt;
      logic [`LSQ_CNTW-1:0] shd;
      logic en_m;
      logic en_s;
      logic sup_m;
      logic sup_s;
      logic [`LSQ_NCH-1:0] cs_m;
      logic [`LSQ_NCH-1:0] cs_s;
      logic [`LSQ_NCH-1:0] op_m;
      logic [`LSQ_NCH-1:0] op_s;
      logic [`LSQ_NCH-1:0] sh_m;
      logic [`LSQ_NCH-1:0] sh_s;
      logic [`LSQ_NCH-1:0] hv_m;
      logic [`LSQ_NCH-1:0] hv_s;
      logic ot_m;
      logic ot_s;
      logic hr_m;
      logic hr_s;
      logic [`LSQ_NCH-1:0] used;
      logic [`LSQ_NCH-1:0] gate;
      logic [`LSQ_SELW-1:0] sel;
      logic fb;
      logic alarm_oe;
      logic alarm_out;
   } lsq_regs_t;
endpackage : lsq_pkg

// ---- core/lsq_top.sv ----
// led string start-up, dimming gate and fault sequencer
`timescale 1ns/1ps
`default_nettype none
`include "lsq_params.svh"

// How it works
// - start only with enable high, supply good
// - first 256 us phase samples channel use
// - sense below threshold means active channel
// - idle channels gated off until the next start-up
// - 128 ms soft-start forces feedback high
// - pick highest-voltage string, feedback from compare
// - open or short protection blanked for 256 ms first
// - armed open or short shuts channels off
// - any protection trips: leds off, alarm low
// - enable is chip enable and dimming gate
// - shutdown only after 32 ms low
module lsq_top #(
   parameter int DETECT_CYC = `LSQ_US_CYC(`LSQ_DETECT_US),
   parameter int SOFT_CYC = `LSQ_MS_CYC(`LSQ_SOFT_MS),
   parameter int BLANK_CYC = `LSQ_MS_CYC(`LSQ_BLANK_MS),
   parameter int SHDN_CYC = `LSQ_MS_CYC(`LSQ_SHDN_MS)
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic enable_dim_pin,
   input wire logic supply_lockout_ok,
   input wire logic [`LSQ_NCH-1:0] cs_below_ref,
   input wire logic [`LSQ_NCH-1:0] open_string_protect,
   input wire logic [`LSQ_NCH-1:0] short_string_protect,
   input wire logic [`LSQ_NCH-1:0] string_highest_vf,
   input wire logic over_temp,
   input wire logic sense_below_setpoint,
   output logic [`LSQ_NCH-1:0] gate_drive,
   output logic [`LSQ_NCH-1:0] channel_active,
   output logic [`LSQ_SELW-1:0] sense_string_sel,
   output logic headroom_feedback_output,
   output logic fault_alarm_out,
   output logic fault_alarm_oe
);
   // ==========================================================
   // elaboration checks
   localparam int CMAX = 2 ** `LSQ_CNTW;
   if (DETECT_CYC < 1 || SOFT_CYC < 1 || BLANK_CYC < 1 || SHDN_CYC < 1 ||
       DETECT_CYC >= CMAX || SOFT_CYC >= CMAX || BLANK_CYC >= CMAX ||
       SHDN_CYC >= CMAX)
   begin : g_bad_count
      $error("lsq_top: phase count out of counter range");
   end

   localparam logic [`LSQ_CNTW-1:0] DET_LAST = `LSQ_CNTW'(DETECT_CYC - 1);
   localparam logic [`LSQ_CNTW-1:0] SOFT_LAST = `LSQ_CNTW'(SOFT_CYC - 1);
   localparam logic [`LSQ_CNTW-1:0] BLANK_LAST = `LSQ_CNTW'(BLANK_CYC - 1);
   localparam logic [`LSQ_CNTW-1:0] SHDN_LAST = `LSQ_CNTW'(SHDN_CYC - 1);

   lsq_pkg::lsq_regs_t r_reg;
   lsq_pkg::lsq_regs_t r_next;
   logic powered;
   logic armed_trip;

   // ==========================================================
   // next state
   always_comb
   begin
      r_next = r_reg;
      // pins are asynchronous: two flops before any use
      r_next.en_m = enable_dim_pin;
      r_next.en_s = r_reg.en_m;
      r_next.sup_m = supply_lockout_ok;
      r_next.sup_s = r_reg.sup_m;
      r_next.cs_m = cs_below_ref;
      r_next.cs_s = r_reg.cs_m;
      r_next.op_m = open_string_protect;
      r_next.op_s = r_reg.op_m;
      r_next.sh_m = short_string_protect;
      r_next.sh_s = r_reg.sh_m;
      r_next.hv_m = string_highest_vf;
      r_next.hv_s = r_reg.hv_m;
      r_next.ot_m = over_temp;
      r_next.ot_s = r_reg.ot_m;
      r_next.hr_m = sense_below_setpoint;
      r_next.hr_s = r_reg.hr_m;
      r_next.cnt = r_reg.cnt + `LSQ_CNTW'(1);
      powered = (r_reg.st != lsq_pkg::ST_OFF);
      armed_trip = (r_reg.st == lsq_pkg::ST_RUN) &&
                   (|((r_reg.op_s | r_reg.sh_s) & r_reg.used));
      // long low enable counts toward shutdown
      // enable back high clears it, phase kept
      if (r_reg.en_s || !powered)
         r_next.shd = '0;
      else
         r_next.shd = r_reg.shd + `LSQ_CNTW'(1);

      unique case (r_reg.st)
         lsq_pkg::ST_OFF:
         begin
            r_next.cnt = '0;
            // wait for enable and good supply
            if (r_reg.en_s && r_reg.sup_s)
               r_next.st = lsq_pkg::ST_DETECT;
         end
         lsq_pkg::ST_DETECT:
         begin
            // sample at end of detection window
            if (r_reg.cnt == DET_LAST)
            begin
               r_next.used = r_reg.cs_s;
               r_next.st = lsq_pkg::ST_SOFT;
               r_next.cnt = '0;
            end
         end
         lsq_pkg::ST_SOFT:
         begin
            if (r_reg.cnt == SOFT_LAST)
            begin
               r_next.st = lsq_pkg::ST_BLANK;
               r_next.cnt = '0;
            end
         end
         lsq_pkg::ST_BLANK:
         begin
            if (r_reg.cnt == BLANK_LAST)
            begin
               r_next.st = lsq_pkg::ST_RUN;
               r_next.cnt = '0;
            end
         end
         lsq_pkg::ST_RUN:
         begin
            r_next.cnt = '0;
            if (armed_trip)
               r_next.st = lsq_pkg::ST_FAULT;
         end
         lsq_pkg::ST_FAULT:
         begin
            // latched until shutdown or supply loss
            r_next.cnt = '0;
         end
         default:
         begin
            r_next.st = lsq_pkg::ST_OFF;
         end
      endcase

      // thermal trip in any powered phase
      if (powered && r_reg.ot_s)
         r_next.st = lsq_pkg::ST_FAULT;
      // full shutdown after long low enable
      if ((powered && r_reg.shd == SHDN_LAST) || !r_reg.sup_s)
      begin
         r_next.st = lsq_pkg::ST_OFF;
         r_next.shd = '0;
         r_next.used = '0;
      end

      // lowest-numbered flagged active string drives the sense node
      for (int i = `LSQ_NCH - 1; i >= 0; i--)
      begin
         if (r_reg.used[i] && r_reg.hv_s[i])
            r_next.sel = `LSQ_SELW'(i);
      end

      // idle channels stay off after detection
      r_next.gate = '0;
      if (r_reg.en_s)
      begin
         unique case (r_next.st)
            lsq_pkg::ST_DETECT: r_next.gate = '1;
            lsq_pkg::ST_SOFT,
            lsq_pkg::ST_BLANK,
            lsq_pkg::ST_RUN: r_next.gate = r_next.used;
            default: r_next.gate = '0;
         endcase
      end

      // afterwards low while sense below setpoint
      // low feedback makes the converter raise its output
      r_next.fb = (r_next.st == lsq_pkg::ST_SOFT) ||
                  (((r_next.st == lsq_pkg::ST_BLANK) ||
                    (r_next.st == lsq_pkg::ST_RUN)) && !r_reg.hr_s);
      // open drain alarm pulls low in fault
      r_next.alarm_oe = (r_next.st == lsq_pkg::ST_FAULT);
      r_next.alarm_out = 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         r_reg <= '0;
         r_reg.st <= lsq_pkg::ST_OFF;
      end
      else
         r_reg <= r_next;
   end

   assign gate_drive = r_reg.gate;
   assign channel_active = r_reg.used;
   assign sense_string_sel = r_reg.sel;
   assign headroom_feedback_output = r_reg.fb;
   assign fault_alarm_out = r_reg.alarm_out;
   assign fault_alarm_oe = r_reg.alarm_oe;

   // ==========================================================
   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence seq_ready_off;
      r_reg.st == lsq_pkg::ST_OFF && r_reg.en_s && r_reg.sup_s;
   endsequence
   sequence seq_detect_end;
      r_reg.st == lsq_pkg::ST_DETECT && r_reg.cnt == DET_LAST &&
      r_reg.sup_s && !r_reg.ot_s && r_reg.shd != SHDN_LAST;
   endsequence

   AST_START: assert property (seq_ready_off |=>
      r_reg.st == lsq_pkg::ST_DETECT)
      else $error("start-up did not begin");
   AST_DETECT_END: assert property (seq_detect_end |=>
      r_reg.st == lsq_pkg::ST_SOFT && r_reg.cnt == '0)
      else $error("detection window wrong length");
   AST_CLASSIFY: assert property (seq_detect_end |=>
      r_reg.used == $past(r_reg.cs_s))
      else $error("channel class not taken from sense");
   AST_IDLE_OFF: assert property (
      r_reg.st != lsq_pkg::ST_DETECT |-> (r_reg.gate & ~r_reg.used) == '0)
      else $error("idle channel driven");
   AST_SOFT_FB: assert property (
      r_reg.st == lsq_pkg::ST_SOFT |-> r_reg.fb)
      else $error("feedback not high in soft-start");
   AST_FB_TRACK: assert property (
      (r_reg.st == lsq_pkg::ST_RUN) |-> r_reg.fb == !$past(r_reg.hr_s))
      else $error("feedback not following compare");
   AST_BLANKED: assert property (
      r_reg.st == lsq_pkg::ST_BLANK && !r_reg.ot_s |=>
      r_reg.st != lsq_pkg::ST_FAULT)
      else $error("protection acted while blanked");
   AST_TRIP: assert property (
      armed_trip && !r_reg.ot_s && r_reg.sup_s &&
      r_reg.shd != SHDN_LAST |=> r_reg.st == lsq_pkg::ST_FAULT &&
      r_reg.gate == '0 && r_reg.alarm_oe)
      else $error("armed fault did not shut channels");
   AST_ALARM: assert property (
      r_reg.st == lsq_pkg::ST_FAULT |-> r_reg.alarm_oe &&
      r_reg.gate == '0)
      else $error("fault without alarm or with leds on");
   AST_DIM_GATE: assert property (!r_reg.en_s |=>
      r_reg.gate == '0)
      else $error("channels on while enable low");
   AST_SHUTDOWN: assert property (
      r_reg.st != lsq_pkg::ST_OFF && r_reg.shd == SHDN_LAST |=>
      r_reg.st == lsq_pkg::ST_OFF)
      else $error("no shutdown after long low");
   AST_KEEP: assert property (
      r_reg.en_s && r_reg.sup_s && r_reg.st != lsq_pkg::ST_OFF &&
      r_reg.shd != SHDN_LAST |=>
      r_reg.st != lsq_pkg::ST_OFF && r_reg.shd == '0)
      else $error("short low restarted sequence");
endmodule : lsq_top
`default_nettype wire

// ---- sim/lsq_host_model.sv ----
// host dimming source model for the led sequencer bench
`timescale 1ns/1ps
`default_nettype none

module lsq_host_model (
   input wire logic clock,
   input wire logic level,
   input wire logic pwm_on,
   input wire logic [7:0] hi_cyc,
   output logic enable_dim_pin
);
   // starts at zero so the pulse phase is known
   logic [3:0] ph_reg = 4'h0;

   // ====================
   // dimming pulse source
   // host pulse dimming
   // free-running phase, so pulses do not line up with bench steps
   always @(posedge clock)
   begin
      ph_reg <= ph_reg + 4'h1;
      enable_dim_pin <= pwm_on ? ({4'h0, ph_reg} < hi_cyc) : level;
   end
endmodule : lsq_host_model
`default_nettype wire

// ---- sim/lsq_top_tb.sv ----
// self-checking bench for the led start-up and fault sequencer
`timescale 1ns/1ps
`default_nettype none

module lsq_top_tb;
   // shortened phase counts keep the run brief
   localparam int DET = 20;
   localparam int SFT = 50;
   localparam int BLK = 60;
   localparam int SHD = 40;
   logic clock, rst, level, pwm_on, en, sup, ot, sbs, fb, aout, aoe;
   logic [7:0] hi_cyc, cs, opn, sht, hvf, gate, act;
   logic [2:0] sel;
   int error_cnt = 0;
   int total_checks = 0;
   int cyc = 0;

   // ====================
   // design and host model
   lsq_host_model i_lsq_host_model (.clock(clock), .level(level),
      .pwm_on(pwm_on), .hi_cyc(hi_cyc), .enable_dim_pin(en));
   lsq_top #(.DETECT_CYC(DET), .SOFT_CYC(SFT), .BLANK_CYC(BLK),
      .SHDN_CYC(SHD)) i_lsq_top (.clock(clock), .rst(rst),
      .enable_dim_pin(en), .supply_lockout_ok(sup), .cs_below_ref(cs),
      .open_string_protect(opn), .short_string_protect(sht),
      .string_highest_vf(hvf), .over_temp(ot),
      .sense_below_setpoint(sbs), .gate_drive(gate),
      .channel_active(act), .sense_string_sel(sel),
      .headroom_feedback_output(fb), .fault_alarm_out(aout),
      .fault_alarm_oe(aoe));

   // ====================
   // shared tasks
   task automatic check(input string nm, input logic [7:0] seen,
      input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic step(input int n);
      repeat (n) @(posedge clock);
   endtask : step

   // bounded wait for all gates on at start-up
   task automatic wait_on();
      int i;
      for (i = 0; i < 8; i++)
         if (gate !== 8'hFF)
            @(posedge clock);
   endtask : wait_on

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test

   // ====================
   // scenarios
   task automatic t_start();
      level <= 1'h1;
      step(10);
      check("gate no supply", gate, 8'h00);
      sup <= 1'h1;
      wait_on();
      check("gate detect", gate, 8'hFF);
      step(DET + 6);
      check("active", act, 8'hA5);
      check("gate idle off", gate, 8'hA5);
      check("fb soft", {7'h00, fb}, 8'h01);
      opn <= 8'hFF;
      step(8);
      check("alarm blanked", {7'h00, aoe}, 8'h00);
      opn <= 8'h00;
      step(SFT - 2);
      check("fb compare", {7'h00, fb}, 8'h00);
      check("sense sel", {5'h00, sel}, 8'h02);
      sbs <= 1'h0;
      step(4);
      check("fb compare", {7'h00, fb}, 8'h01);
      step(BLK + 4);
      $display("test start done");
   endtask : t_start

   task automatic t_dim();
      int n;
      n = 0;
      level <= 1'h0;
      step(8);
      check("gate dim low", gate, 8'h00);
      level <= 1'h1;
      step(5);
      check("gate dim high", gate, 8'hA5);
      check("active kept", act, 8'hA5);
      pwm_on <= 1'h1;
      step(6);
      repeat (60)
      begin
         @(posedge clock);
         if (gate === 8'hA5)
            n++;
      end
      check("pulse count", {7'h00, n >= 3 && n <= 4}, 8'h01);
      pwm_on <= 1'h0;
      step(5);
      check("gate after pwm", gate, 8'hA5);
      $display("test dimming done");
   endtask : t_dim

   task automatic t_fault();
      sht <= 8'h01;
      step(5);
      check("gate fault", gate, 8'h00);
      check("alarm oe", {7'h00, aoe}, 8'h01);
      check("alarm out", {7'h00, aout}, 8'h00);
      sht <= 8'h00;
      step(5);
      check("alarm held", {7'h00, aoe}, 8'h01);
      $display("test fault done");
   endtask : t_fault

   task automatic t_shdn();
      level <= 1'h0;
      step(SHD + 8);
      check("alarm shdn", {7'h00, aoe}, 8'h00);
      level <= 1'h1;
      wait_on();
      check("restart", gate, 8'hFF);
      ot <= 1'h1;
      step(5);
      check("thermal alarm", {7'h00, aoe}, 8'h01);
      check("thermal gate", gate, 8'h00);
      ot <= 1'h0;
      sup <= 1'h0;
      step(4);
      check("supply loss", act, 8'h00);
      check("supply loss alarm", {7'h00, aoe}, 8'h00);
      $display("test shutdown done");
   endtask : t_shdn

   // ====================
   // clock, watchdog, main
   initial
   begin
      clock = 1'h0;
      forever #4 clock = ~clock;
   end

   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         error_cnt++;
         finish_test();
      end
   end

   initial
   begin
      rst = 1'h1;
      level = 1'h0;
      pwm_on = 1'h0;
      hi_cyc = 8'h01;
      sup = 1'h0;
      ot = 1'h0;
      sbs = 1'h1;
      cs = 8'hA5;
      opn = 8'h00;
      sht = 8'h00;
      hvf = 8'h24;
      step(8);
      rst <= 1'h0;
      step(1);
      check("gate reset", gate, 8'h00);
      t_start();
      t_dim();
      t_fault();
      t_shdn();
      finish_test();
   end
endmodule : lsq_top_tb
`default_nettype wire
